// ---- design/tsiic_map.vh ----
// Register map, field positions and timing constants of the status block
`ifndef TSIIC_MAP_VH
`define TSIIC_MAP_VH

// ----------------------------------------------------------------------
// Register offsets on the host address bus
// ----------------------------------------------------------------------
`define TSIIC_ADDR_FILL_ONE    8'h03
`define TSIIC_ADDR_FILL_TWO    8'h04
`define TSIIC_ADDR_FILL_THREE  8'h05
`define TSIIC_ADDR_GLOBAL_GATE 8'h06
`define TSIIC_ADDR_EVENT_FLAGS 8'h07
`define TSIIC_ADDR_EVENT_MASK  8'h08

// ----------------------------------------------------------------------
// Event flag and mask bit positions
// ----------------------------------------------------------------------
`define TSIIC_BIT_FRAME_FAULT  6
`define TSIIC_BIT_PAT_LOCK     5
`define TSIIC_BIT_RSVD_FOUR    4
`define TSIIC_BIT_PAT_ERROR    3
`define TSIIC_BIT_RSVD_TWO     2
`define TSIIC_BIT_SELFTEST     1
`define TSIIC_BIT_INSERT_DONE  0
`define TSIIC_BIT_GLOBAL_EN    0

// ----------------------------------------------------------------------
// Reset values and read-back masks
// ----------------------------------------------------------------------
`define TSIIC_RST_FILL         8'h00
`define TSIIC_RST_GLOBAL_EN    1'h0
`define TSIIC_RST_FLAGS        8'h00
`define TSIIC_RST_MASK         8'h7F
`define TSIIC_FLAGS_LIVE       8'h6B
`define TSIIC_MASK_LIVE        8'h6B
`define TSIIC_MASK_ONES        8'h14
`define TSIIC_READ_UNMAPPED    8'h00

// ----------------------------------------------------------------------
// Outgoing slot data-select codes
// ----------------------------------------------------------------------
`define TSIIC_SEL_SWITCHED     2'h0
`define TSIIC_SEL_FILL_ONE     2'h1
`define TSIIC_SEL_FILL_TWO     2'h2
`define TSIIC_SEL_FILL_THREE   2'h3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define TSIIC_FRAME_TIME_NS    125000
`define TSIIC_CLK_PERIOD_NS    20
`define TSIIC_LOCK_SLOTS       32

`endif

// ---- design/tsiic_sync.v ----
// Two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/1ns

module tsiic_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input  wire             core_clk,
  input  wire             rst,
  // Pins and settled copy
  input  wire [WIDTH-1:0] pinIn,
  input  wire [WIDTH-1:0] resetLevel,
  output reg  [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stageOne;

  // First stage feeds only the second; resetLevel is a constant at each use
  always @(posedge core_clk) begin
    if (rst) begin
      stageOne <= resetLevel;
      syncOut  <= resetLevel;
    end else begin
      stageOne <= pinIn;
      syncOut  <= stageOne;
    end
  end

endmodule // tsiic_sync

// ---- design/tsiic_pattern_lock.v ----
// Lock tracker of the test-pattern checker: counts clean slots, flags errors
`timescale 1ns/1ns
`include "tsiic_map.vh"

module tsiic_pattern_lock #(
  parameter LOCK_SLOTS = `TSIIC_LOCK_SLOTS,
  parameter CNT_W      = 6
) (
  // Clock and reset
  input  wire core_clk,
  input  wire rst,
  // Checker slot results
  input  wire checkerRun,
  input  wire slotChecked,
  input  wire slotMismatch,
  // Lock state and error events
  output reg  patternLocked,
  output reg  errorPulse
);

  localparam [31:0]      LAST_FULL = LOCK_SLOTS - 1;
  localparam [CNT_W-1:0] LAST_SLOT = LAST_FULL[CNT_W-1:0];

  reg [CNT_W-1:0] cleanCount;

  // Clean slots accumulate across frames, so few checked slots still lock
  always @(posedge core_clk) begin
    if (rst || !checkerRun) begin
      cleanCount    <= {CNT_W{1'b0}};
      patternLocked <= 1'b0;
      errorPulse    <= 1'b0;
    end else begin
      errorPulse <= 1'b0;
      if (slotChecked) begin
        if (patternLocked) begin
          errorPulse <= slotMismatch;
        end else if (slotMismatch) begin
          cleanCount <= {CNT_W{1'b0}};
        end else if (cleanCount == LAST_SLOT) begin
          patternLocked <= 1'b1;
        end else begin
          cleanCount <= cleanCount + 1'b1;
        end
      end
    end
  end

endmodule // tsiic_pattern_lock

// ---- design/tsiic_status_regs.v ----
// Host registers: fill bytes, event flags, masks and interrupt gate
//
// How it works
// - Slots selecting fill one send fill_byte_one
// - Slots selecting fill two send fill_byte_two
// - Slots selecting fill three send fill_byte_three
// - Slot data-select bits choose fill transmission
// - Global enable low holds interrupt off
// - Enabled, unmasked set flag raises interrupt
// - Missing or misaligned frame pulse sets bit 6
// - Bit 5 is set while pattern checker is locked, held until read
// - Lock needs 32 clean checked slots
// - Errors after lock set bit 3
// - Self-test finish sets bit 1
// - All error insertions done sets bit 0
// - Reserved flag and gate bits read fixed
// - Reading flags clears them until next event
// - Flags update regardless of mask, except bit 6
// - Frame mask set suppresses frame fault detection
// - Per-bit masks, all resetting to one
`timescale 1ns/1ns
`include "tsiic_map.vh"

module tsiic_status_regs #(
  parameter FRAME_CYCLES = `TSIIC_FRAME_TIME_NS / `TSIIC_CLK_PERIOD_NS,
  parameter FRAME_W      = 16,
  parameter LOCK_SLOTS   = `TSIIC_LOCK_SLOTS
) (
  // Clock and reset
  input  wire       core_clk,
  input  wire       rst,
  // Host pins, strobes active low
  input  wire [7:0] hostAddr,
  input  wire [7:0] hostDataIn,
  output reg  [7:0] hostDataOut,
  output reg        hostDataOe,
  input  wire       hostSel_n,
  input  wire       hostRead_n,
  input  wire       hostWrite_n,
  // Interrupt request, active high
  output reg        irqReq,
  // Frame pulse pin
  input  wire       frame_pulse,
  // Outgoing slot path
  input  wire [1:0] slotDataSelect,
  input  wire [7:0] slotSwitchedData,
  input  wire       slotStrobe,
  output reg  [7:0] slotTxData,
  // Event sources on the core clock
  input  wire       checkerRun,
  input  wire       checkSlotValid,
  input  wire       checkSlotMismatch,
  input  wire       selftestDone,
  input  wire       errorInsertDone,
  // Live status
  output wire       patternLocked
);

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  localparam PIN_W = 20;
  localparam [PIN_W-1:0] PIN_IDLE = {1'b0, 3'h7, 8'h00, 8'h00};

  wire [PIN_W-1:0] pinsSynced;
  wire [7:0]       busAddr;
  wire [7:0]       busData;
  wire             busSel;
  wire             busRd;
  wire             busWr;
  wire             framePin;

  tsiic_sync #(
    .WIDTH      (PIN_W)
  ) u_pinSync (
    .core_clk   (core_clk),
    .rst        (rst),
    .pinIn      ({frame_pulse, hostSel_n, hostRead_n, hostWrite_n,
                  hostAddr, hostDataIn}),
    .resetLevel (PIN_IDLE),
    .syncOut    (pinsSynced)
  );

  // Strobes are turned active high once settled
  assign framePin = pinsSynced[19];
  assign busSel   = ~pinsSynced[18];
  assign busRd    = ~pinsSynced[17] & busSel;
  assign busWr    = ~pinsSynced[16] & busSel;
  assign busAddr  = pinsSynced[15:8];
  assign busData  = pinsSynced[7:0];

  // --------------------------------------------------------------------
  // Strobe edge detection
  // --------------------------------------------------------------------
  reg  busRdDly;
  reg  busWrDly;
  reg  framePinDly;
  wire readStart;
  wire writeStart;
  wire frameEdge;

  // Act once per access on the leading edge of the settled strobe
  always @(posedge core_clk) begin
    if (rst) begin
      busRdDly    <= 1'b0;
      busWrDly    <= 1'b0;
      framePinDly <= 1'b0;
    end else begin
      busRdDly    <= busRd;
      busWrDly    <= busWr;
      framePinDly <= framePin;
    end
  end

  assign readStart  = busRd & ~busRdDly;
  assign writeStart = busWr & ~busWrDly;
  assign frameEdge  = framePin & ~framePinDly;

  // --------------------------------------------------------------------
  // Writable registers
  // --------------------------------------------------------------------
  reg [7:0] fillByteOne;
  reg [7:0] fillByteTwo;
  reg [7:0] fillByteThree;
  reg       globalIrqEnable;
  reg [7:0] eventMask;

  // Reserved mask bits are not stored; they are forced on read-back
  always @(posedge core_clk) begin
    if (rst) begin
      fillByteOne     <= `TSIIC_RST_FILL;
      fillByteTwo     <= `TSIIC_RST_FILL;
      fillByteThree   <= `TSIIC_RST_FILL;
      globalIrqEnable <= `TSIIC_RST_GLOBAL_EN;
      eventMask       <= `TSIIC_RST_MASK;
    end else if (writeStart) begin
      case (busAddr)
        `TSIIC_ADDR_FILL_ONE: begin
          fillByteOne <= busData;
        end
        `TSIIC_ADDR_FILL_TWO: begin
          fillByteTwo <= busData;
        end
        `TSIIC_ADDR_FILL_THREE: begin
          fillByteThree <= busData;
        end
        `TSIIC_ADDR_GLOBAL_GATE: begin
          globalIrqEnable <= busData[`TSIIC_BIT_GLOBAL_EN];
        end
        `TSIIC_ADDR_EVENT_MASK: begin
          eventMask <= busData & `TSIIC_MASK_LIVE;
        end
        default: begin
          eventMask <= eventMask;  // Flags and unmapped writes do nothing
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Outgoing slot data selection
  // --------------------------------------------------------------------
  reg [7:0] next_slotTxData;

  // The slot's own select code picks the source, not the fill registers
  always @* begin
    case (slotDataSelect)
      `TSIIC_SEL_FILL_ONE:   next_slotTxData = fillByteOne;
      `TSIIC_SEL_FILL_TWO:   next_slotTxData = fillByteTwo;
      `TSIIC_SEL_FILL_THREE: next_slotTxData = fillByteThree;
      default:               next_slotTxData = slotSwitchedData;
    endcase
  end

  // Held between strobes so the serialiser sees a stable byte
  always @(posedge core_clk) begin
    if (rst) begin
      slotTxData <= `TSIIC_RST_FILL;
    end else if (slotStrobe) begin
      slotTxData <= next_slotTxData;
    end
  end

  // --------------------------------------------------------------------
  // Frame pulse supervision
  // --------------------------------------------------------------------
  localparam [31:0]        FRAME_FULL = FRAME_CYCLES - 1;
  localparam [FRAME_W-1:0] FRAME_LAST = FRAME_FULL[FRAME_W-1:0];

  reg  [FRAME_W-1:0] frameCount;
  reg                frameArmed;
  reg                frameFault;
  wire               frameMasked;

  assign frameMasked = eventMask[`TSIIC_BIT_FRAME_FAULT];

  // Disarmed while masked, so the first pulse after unmasking only aligns;
  // a pulse off the boundary or a boundary without a pulse is a fault
  always @(posedge core_clk) begin
    if (rst || frameMasked) begin
      frameCount <= {FRAME_W{1'b0}};
      frameArmed <= 1'b0;
      frameFault <= 1'b0;
    end else if (frameEdge) begin
      frameCount <= {FRAME_W{1'b0}};
      frameArmed <= 1'b1;
      frameFault <= frameArmed && (frameCount != FRAME_LAST);
    end else if (frameCount == FRAME_LAST) begin
      frameCount <= {FRAME_W{1'b0}};
      frameFault <= frameArmed;
    end else begin
      frameCount <= frameCount + 1'b1;
      frameFault <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Pattern checker lock tracking
  // --------------------------------------------------------------------
  wire patternError;

  tsiic_pattern_lock #(
    .LOCK_SLOTS    (LOCK_SLOTS)
  ) u_patLock (
    .core_clk      (core_clk),
    .rst           (rst),
    .checkerRun    (checkerRun),
    .slotChecked   (checkSlotValid),
    .slotMismatch  (checkSlotMismatch),
    .patternLocked (patternLocked),
    .errorPulse    (patternError)
  );

  // --------------------------------------------------------------------
  // Event flags
  // --------------------------------------------------------------------
  reg  [7:0] eventFlags;
  reg  [7:0] eventSet;
  wire       flagsRead;

  assign flagsRead = readStart && (busAddr == `TSIIC_ADDR_EVENT_FLAGS);

  // Sources other than the frame fault ignore the mask
  always @* begin
    eventSet = 8'h00;
    eventSet[`TSIIC_BIT_FRAME_FAULT] = frameFault;
    eventSet[`TSIIC_BIT_PAT_LOCK]    = patternLocked;
    eventSet[`TSIIC_BIT_PAT_ERROR]   = patternError;
    eventSet[`TSIIC_BIT_SELFTEST]    = selftestDone;
    eventSet[`TSIIC_BIT_INSERT_DONE] = errorInsertDone;
  end

  // Set beats the read clear so a coincident event is never lost;
  // the lock bit is re-set every cycle while locked, so after the lock drops it stays set until read
  always @(posedge core_clk) begin
    if (rst) begin
      eventFlags <= `TSIIC_RST_FLAGS;
    end else if (flagsRead) begin
      eventFlags <= eventSet & `TSIIC_FLAGS_LIVE;
    end else begin
      eventFlags <= (eventFlags | eventSet) & `TSIIC_FLAGS_LIVE;
    end
  end

  // --------------------------------------------------------------------
  // Host read path
  // --------------------------------------------------------------------
  reg [7:0] next_readData;

  // Reserved bits come out fixed whatever was written
  always @* begin
    case (busAddr)
      `TSIIC_ADDR_FILL_ONE:    next_readData = fillByteOne;
      `TSIIC_ADDR_FILL_TWO:    next_readData = fillByteTwo;
      `TSIIC_ADDR_FILL_THREE:  next_readData = fillByteThree;
      `TSIIC_ADDR_GLOBAL_GATE: next_readData = {7'h00, globalIrqEnable};
      `TSIIC_ADDR_EVENT_FLAGS: next_readData = eventFlags;
      `TSIIC_ADDR_EVENT_MASK:  next_readData = eventMask | `TSIIC_MASK_ONES;
      default:                 next_readData = `TSIIC_READ_UNMAPPED;
    endcase
  end

  // Data is captured at the start of the read and held until it ends
  always @(posedge core_clk) begin
    if (rst) begin
      hostDataOut <= `TSIIC_READ_UNMAPPED;
      hostDataOe  <= 1'b0;
    end else begin
      hostDataOe <= busRd;
      if (readStart) begin
        hostDataOut <= next_readData;
      end
    end
  end

  // --------------------------------------------------------------------
  // Interrupt request
  // --------------------------------------------------------------------
  // Registered so the pin never glitches while flags and masks change
  always @(posedge core_clk) begin
    if (rst) begin
      irqReq <= 1'b0;
    end else begin
      irqReq <= globalIrqEnable &
                (|(eventFlags & ~eventMask));
    end
  end

endmodule // tsiic_status_regs

// ---- sim/tsiic_status_props.sv ----
// Pin-level assertions for the status register block
`timescale 1ns/1ns
`include "tsiic_map.vh"

module tsiic_status_props #(
  parameter LOCK_SLOTS = 32
) (
  // Clock and reset
  input wire       core_clk,
  input wire       rst,
  // Host pins
  input wire [7:0] hostAddr,
  input wire [7:0] hostDataOut,
  input wire       hostDataOe,
  input wire       hostSel_n,
  input wire       hostRead_n,
  input wire       hostWrite_n,
  input wire       irqReq,
  // Slot path and pattern checker
  input wire [1:0] slotDataSelect,
  input wire [7:0] slotSwitchedData,
  input wire       slotStrobe,
  input wire [7:0] slotTxData,
  input wire       checkerRun,
  input wire       checkSlotValid,
  input wire       checkSlotMismatch,
  input wire       patternLocked
);
  reg [6:0] cleanCnt;
  reg       wrSeen;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Clean slot run and first host write, tracked beside the block
  always @(posedge core_clk) begin
    if (rst || !checkerRun || (checkSlotValid && checkSlotMismatch))
      cleanCnt <= 7'h00;
    else if (checkSlotValid && cleanCnt != 7'h7F)
      cleanCnt <= cleanCnt + 7'h01;
    wrSeen <= !rst && (wrSeen || (!hostSel_n && !hostWrite_n));
  end

  property p_slotSwitched;
    slotStrobe && slotDataSelect == `TSIIC_SEL_SWITCHED
      |=> slotTxData == $past(slotSwitchedData);
  endproperty
  a_slotSwitched: assert property (p_slotSwitched)
    else $error("switched byte not sent");

  property p_slotHold;
    !slotStrobe |=> $stable(slotTxData);
  endproperty
  a_slotHold: assert property (p_slotHold)
    else $error("slot byte changed without strobe");

  property p_lockCount;
    $rose(patternLocked) |-> cleanCnt >= LOCK_SLOTS;
  endproperty
  a_lockCount: assert property (p_lockCount)
    else $error("lock before a full clean run");

  property p_lockDrop;
    !checkerRun [*3] |-> !patternLocked;
  endproperty
  a_lockDrop: assert property (p_lockDrop)
    else $error("lock held with checker stopped");

  property p_noEarlyIrq;
    !wrSeen |-> !irqReq;
  endproperty
  a_noEarlyIrq: assert property (p_noEarlyIrq)
    else $error("request raised with reset gate and masks");

  property p_gateRsvd;
    hostDataOe && !hostRead_n && hostAddr == `TSIIC_ADDR_GLOBAL_GATE
      |-> hostDataOut[7:1] == 7'h00;
  endproperty
  a_gateRsvd: assert property (p_gateRsvd)
    else $error("gate reserved bits not zero");

  property p_flagsRsvd;
    hostDataOe && !hostRead_n && hostAddr == `TSIIC_ADDR_EVENT_FLAGS
      |-> (hostDataOut & 8'h94) == 8'h00;
  endproperty
  a_flagsRsvd: assert property (p_flagsRsvd)
    else $error("flag reserved bits not zero");

  property p_maskRsvd;
    hostDataOe && !hostRead_n && hostAddr == `TSIIC_ADDR_EVENT_MASK
      |-> (hostDataOut & 8'h94) == 8'h14;
  endproperty
  a_maskRsvd: assert property (p_maskRsvd)
    else $error("mask reserved bits wrong");
endmodule // tsiic_status_props

bind tsiic_status_regs tsiic_status_props #(.LOCK_SLOTS(LOCK_SLOTS)) u_props (
  .core_clk(core_clk), .rst(rst), .hostAddr(hostAddr),
  .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
  .hostSel_n(hostSel_n), .hostRead_n(hostRead_n),
  .hostWrite_n(hostWrite_n), .irqReq(irqReq),
  .slotDataSelect(slotDataSelect), .slotSwitchedData(slotSwitchedData),
  .slotStrobe(slotStrobe), .slotTxData(slotTxData),
  .checkerRun(checkerRun), .checkSlotValid(checkSlotValid),
  .checkSlotMismatch(checkSlotMismatch), .patternLocked(patternLocked)
);

// ---- sim/tsiic_host_model.sv ----
// Host processor model on the register pins of the status block
`timescale 1ns/1ns

module tsiic_host_model (
  // Clock
  input  wire       core_clk,
  // Host pins
  output reg  [7:0] hostAddr,
  output wire [7:0] hostDataIn,
  output reg        hostSel_n,
  output reg        hostRead_n,
  output reg        hostWrite_n,
  // Read drive of the block
  input  wire [7:0] hostDataOut,
  input  wire       hostDataOe,
  // Last read went unanswered
  output reg        timedOut
);
  reg [7:0] wrData;
  reg       wrDrive;
  reg [7:0] lastBus;

  // Undriven bus flips every cycle so a stale byte never looks valid
  assign hostDataIn = hostDataOe ? hostDataOut
                    : wrDrive ? wrData : ~lastBus;

  always @(posedge core_clk)
    lastBus <= hostDataIn;

  initial begin
    hostAddr = 8'h00;
    hostSel_n = 1'b1;
    hostRead_n = 1'b1;
    hostWrite_n = 1'b1;
    wrData = 8'h00;
    wrDrive = 1'b0;
    lastBus = 8'h00;
    timedOut = 1'b0;
  end

  // Hold a read until answered or 10 cycles, a write for 4 cycles, then idle 4 cycles for the syncs
  task access(input [7:0] a, input [7:0] d, input rd, output [7:0] q);
    integer n;
    begin
      @(posedge core_clk);
      #1;
      hostAddr = a;
      wrData = d;
      wrDrive = !rd;
      hostSel_n = 1'b0;
      hostRead_n = !rd;
      hostWrite_n = rd;
      n = 0;
      do begin
        @(posedge core_clk);
        n = n + 1;
      end while (rd ? (!hostDataOe && n < 10) : n < 4);
      q = hostDataIn;
      timedOut = rd && !hostDataOe;
      #1;
      hostSel_n = 1'b1;
      hostRead_n = 1'b1;
      hostWrite_n = 1'b1;
      wrDrive = 1'b0;
      repeat (4) @(posedge core_clk);
      #1;
    end
  endtask
endmodule // tsiic_host_model

// ---- sim/test_tsiic_status_regs.sv ----
// Self-checking bench of the status register block
`timescale 1ns/1ns
`include "tsiic_map.vh"

module test_tsiic_status_regs;
  localparam FRAME = 20;
  localparam [7:0] FLAGS = `TSIIC_ADDR_EVENT_FLAGS;
  localparam [7:0] MASK  = `TSIIC_ADDR_EVENT_MASK;
  localparam [7:0] GATE  = `TSIIC_ADDR_GLOBAL_GATE;

  reg        core_clk;
  reg        rst;
  reg        frame_pulse;
  reg  [1:0] slotDataSelect;
  reg  [7:0] slotSwitchedData;
  reg        slotStrobe;
  reg        checkerRun;
  reg        checkSlotValid;
  reg        checkSlotMismatch;
  reg        selftestDone;
  reg        errorInsertDone;
  reg        fsOn;
  reg        fsSkew;
  wire [7:0] hostAddr;
  wire [7:0] hostDataIn;
  wire [7:0] hostDataOut;
  wire       hostDataOe;
  wire       hostSel_n;
  wire       hostRead_n;
  wire       hostWrite_n;
  wire       irqReq;
  wire [7:0] slotTxData;
  wire       patternLocked;
  reg  [7:0] fill [1:3];
  reg  [7:0] q;
  integer    fsCnt;
  integer    nFail;
  integer    samplesChecked;
  integer    seed;
  integer    i;
  integer    k;

  tsiic_status_regs #(.FRAME_CYCLES(FRAME)) dut (
    .core_clk(core_clk), .rst(rst),
    .hostAddr(hostAddr), .hostDataIn(hostDataIn),
    .hostDataOut(hostDataOut), .hostDataOe(hostDataOe),
    .hostSel_n(hostSel_n), .hostRead_n(hostRead_n),
    .hostWrite_n(hostWrite_n), .irqReq(irqReq),
    .frame_pulse(frame_pulse), .slotDataSelect(slotDataSelect),
    .slotSwitchedData(slotSwitchedData), .slotStrobe(slotStrobe),
    .slotTxData(slotTxData), .checkerRun(checkerRun),
    .checkSlotValid(checkSlotValid),
    .checkSlotMismatch(checkSlotMismatch),
    .selftestDone(selftestDone), .errorInsertDone(errorInsertDone),
    .patternLocked(patternLocked)
  );

  tsiic_host_model host (
    .core_clk(core_clk), .hostAddr(hostAddr), .hostDataIn(hostDataIn),
    .hostSel_n(hostSel_n), .hostRead_n(hostRead_n),
    .hostWrite_n(hostWrite_n), .hostDataOut(hostDataOut),
    .hostDataOe(hostDataOe), .timedOut()
  );

  // 50 MHz core clock
  always #10 core_clk = ~core_clk;

  // Frame pulse every FRAME cycles while enabled; a skew cycle slips phase
  always @(posedge core_clk) begin
    fsCnt <= (fsCnt + 1 + fsSkew) % FRAME;
    frame_pulse <= fsOn && fsCnt == 0;
  end

  task chk(input [7:0] seen, input [7:0] exp);
    begin
      samplesChecked = samplesChecked + 1;
      if (seen !== exp) begin
        nFail = nFail + 1;
        $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
      end
    end
  endtask

  task reportAndStop;
    begin
      if (nFail == 0 && samplesChecked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  task tick(input integer n);
    begin
      repeat (n) @(posedge core_clk);
      #1;
    end
  endtask

  task wr(input [7:0] a, input [7:0] d);
    host.access(a, d, 1'b0, q);
  endtask

  task rd(input [7:0] a, input [7:0] exp);
    begin
      host.access(a, 8'h00, 1'b1, q);
      if (host.timedOut) begin
        nFail = nFail + 1;
        reportAndStop;
      end else begin
        chk(q, exp);
      end
    end
  endtask

  // Expected outgoing byte for a slot
  function [7:0] slotExp(input [1:0] s, input [7:0] sw);
    slotExp = (s == `TSIIC_SEL_SWITCHED) ? sw : fill[s];
  endfunction

  // Checked slots back to back or with random gaps; last one may fail
  task slots(input integer n, input bad);
    for (k = 0; k < n; k = k + 1) begin
      checkSlotValid = 1'b1;
      checkSlotMismatch = bad && k == n - 1;
      tick(1);
      checkSlotValid = 1'b0;
      checkSlotMismatch = 1'b0;
      if ($random(seed) & 1)
        tick(1);
    end
  endtask

  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    fsOn = 1'b0;
    fsSkew = 1'b0;
    fsCnt = 0;
    frame_pulse = 1'b0;
    slotDataSelect = 2'h0;
    slotSwitchedData = 8'h00;
    slotStrobe = 1'b0;
    checkerRun = 1'b0;
    checkSlotValid = 1'b0;
    checkSlotMismatch = 1'b0;
    selftestDone = 1'b0;
    errorInsertDone = 1'b0;
    nFail = 0;
    samplesChecked = 0;
    seed = 57054;
    tick(4);
    rst = 1'b0;
    // Reset values, unmapped read, refused write
    for (i = 3; i < 8; i = i + 1)
      rd(8'(i), 8'h00);
    rd(MASK, `TSIIC_RST_MASK);
    rd(8'h0A, 8'h00);
    wr(FLAGS, 8'hFF);
    rd(FLAGS, 8'h00);
    // Random fill bytes, then every data-select code back to back
    for (i = 1; i < 4; i = i + 1) begin
      fill[i] = 8'($random(seed));
      wr(8'(i + 2), fill[i]);
      rd(8'(i + 2), fill[i]);
    end
    wr(GATE, 8'hFF);
    rd(GATE, 8'h01);
    for (i = 0; i < 16; i = i + 1) begin
      slotDataSelect = i[1:0];
      slotSwitchedData = 8'($random(seed));
      slotStrobe = 1'b1;
      tick(1);
      chk(slotTxData, slotExp(i[1:0], slotSwitchedData));
    end
    slotStrobe = 1'b0;
    // Masked events still set their flags
    selftestDone = 1'b1;
    errorInsertDone = 1'b1;
    tick(1);
    selftestDone = 1'b0;
    errorInsertDone = 1'b0;
    tick(2);
    chk(irqReq, 1'b0);
    rd(FLAGS, 8'h03);
    rd(FLAGS, 8'h00);
    // Gate and masks together decide the request
    wr(MASK, 8'h7C);
    wr(GATE, 8'h00);
    selftestDone = 1'b1;
    tick(1);
    selftestDone = 1'b0;
    tick(2);
    chk(irqReq, 1'b0);
    wr(GATE, 8'h01);
    chk(irqReq, 1'b1);
    rd(FLAGS, 8'h02);
    chk(irqReq, 1'b0);
    // Event at the very edge that read-clears the flags
    fork
      host.access(FLAGS, 8'h00, 1'b1, q);
      begin
        tick(3);
        errorInsertDone = 1'b1;
        tick(1);
        errorInsertDone = 1'b0;
      end
    join
    rd(FLAGS, 8'h01);
    // Lock needs an unbroken run of clean slots
    checkerRun = 1'b1;
    slots(32, 1'b1);
    slots(31, 1'b0);
    tick(3);
    chk(patternLocked, 1'b0);
    rd(FLAGS, 8'h00);
    slots(1, 1'b0);
    tick(3);
    chk(patternLocked, 1'b1);
    slots(1, 1'b1);
    tick(3);
    rd(FLAGS, 8'h28);
    checkerRun = 1'b0;
    tick(3);
    chk(patternLocked, 1'b0);
    rd(FLAGS, 8'h20);
    // Regular pulses pass; a slipped or a missing one is a fault
    wr(MASK, 8'h3C);
    fsOn = 1'b1;
    tick(5 * FRAME);
    rd(FLAGS, 8'h00);
    fsSkew = 1'b1;
    tick(1);
    fsSkew = 1'b0;
    tick(2 * FRAME);
    rd(FLAGS, 8'h40);
    tick(2 * FRAME);
    rd(FLAGS, 8'h00);
    fsOn = 1'b0;
    tick(3 * FRAME);
    rd(FLAGS, 8'h40);
    // Frame mask set ignores missing pulses
    wr(MASK, 8'h7F);
    host.access(FLAGS, 8'h00, 1'b1, q);
    fsOn = 1'b1;
    tick(2 * FRAME);
    fsOn = 1'b0;
    tick(3 * FRAME);
    rd(FLAGS, 8'h00);
    reportAndStop;
  end
endmodule // test_tsiic_status_regs
